// *** rtl/sse_engine.sv ***
`timescale 1ns/100ps
module sse_engine #(
    parameter int CYCLES_PER_MS = sse_pkg::CYCLES_PER_MS
) (
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    input  wire logic                           linkClk,
    input  wire logic                           stepWrEn,
    input  wire logic                           stepWrList,
    input  wire logic [sse_pkg::STEP_AW-1:0]    stepWrAddr,
    input  wire logic [sse_pkg::STEP_W-1:0]     stepWrData,
    input  wire logic [sse_pkg::STEP_CNT_W-1:0] initSteps,
    input  wire logic [sse_pkg::STEP_CNT_W-1:0] exitSteps,
    input  wire logic                           connectStart,
    input  wire logic                           programDone,
    input  wire logic                           miso,
    output logic                                sck,
    output logic                                mosi,
    output logic                                csN,
    output logic                                busy,
    output logic                                initDone,
    output logic                                exitDone
);
    import sse_pkg::*;

    localparam int TICK_W = $clog2(CYCLES_PER_MS + 1);

    if (CYCLES_PER_MS < 1) begin : g_bad_rate
        $error("CYCLES_PER_MS must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic [STEP_W-1:0]     stepMem [2*STEP_DEPTH];
    logic [7:0]            varBuf_q [BUF_BYTES];
    sse_state_type         state_q;
    logic                  listSel_q;
    logic [STEP_CNT_W-1:0] stepIdx_q;
    logic [STEP_CNT_W-1:0] stepTotal_q;
    sse_op_type            op_q;
    logic [VAL0_W-1:0]     val0_q;
    logic [VAL1_W-1:0]     val1_q;
    logic [BYTE_CNT_W-1:0] byteNum_q;
    logic [BYTE_CNT_W-1:0] byteTotal_q;
    logic [BUF_IDX_W-1:0]  bufPtr_q;
    logic [VAL0_W-1:0]     msLeft_q;
    logic [TICK_W-1:0]     tick_q;
    logic                  reqTgl_q;
    logic [7:0]            txByte_q;
    logic                  ackA_q;
    logic                  ackB_q;
    logic                  ackSeen_q;
    logic                  linkAck;
    logic [7:0]            linkRx;

    logic                  ackNew;
    logic                  lastByte;
    logic [BYTE_CNT_W-1:0] xferCount;
    logic [BYTE_CNT_W-1:0] rawCount;
    logic                  bufWe;
    logic [BUF_IDX_W-1:0]  bufWIdx;
    logic [7:0]            bufWData;
    logic [7:0]            bufOld;
    logic [7:0]            txNext;

    ////////////////////////////////////////////////////////////////////////////////
    // Step store: entries 0..31 hold the init list, 32..63 the exit list

    always_ff @(posedge ref_clk) begin
        if (stepWrEn) begin
            stepMem[{stepWrList, stepWrAddr}] <= stepWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    assign ackNew   = (ackB_q != ackSeen_q);
    assign lastByte = (byteNum_q + 1'b1) == byteTotal_q;
    assign bufOld   = varBuf_q[val0_q[BUF_IDX_W-1:0]];

    // Counts above sixteen are clipped; buffer offsets wrap inside the buffer
    always_comb begin
        if (op_q == OP_WRITE) begin
            rawCount = (val0_q > VAL0_W'(BUF_BYTES)) ? BYTE_CNT_W'(BUF_BYTES)
                                                     : val0_q[BYTE_CNT_W-1:0];
        end else begin
            rawCount = (val1_q[7:0] > 8'(BUF_BYTES)) ? BYTE_CNT_W'(BUF_BYTES)
                                                     : val1_q[BYTE_CNT_W-1:0];
        end
        xferCount = rawCount;
    end

    always_comb begin
        case (op_q)
            OP_WRITE:  txNext = val1_q[{byteNum_q[BUF_IDX_W-1:0], 3'b000} +: 8];
            OP_BUF_WR: txNext = varBuf_q[bufPtr_q];
            default:   txNext = FILL_BYTE;
        endcase
    end

    always_comb begin
        bufWe    = 1'b0;
        bufWIdx  = val0_q[BUF_IDX_W-1:0];
        bufWData = bufOld;
        if (state_q == ST_EXEC) begin
            case (op_q)
                OP_BUF_AND: begin
                    bufWe    = 1'b1;
                    bufWData = bufOld & val1_q[7:0];
                end
                OP_BUF_OR: begin
                    bufWe    = 1'b1;
                    bufWData = bufOld | val1_q[7:0];
                end
                OP_BUF_XOR: begin
                    bufWe    = 1'b1;
                    bufWData = bufOld ^ val1_q[7:0];
                end
                default: begin
                    bufWe = 1'b0;
                end
            endcase
        end else if (state_q == ST_WAIT && ackNew && op_q == OP_BUF_RD) begin
            bufWe    = 1'b1;
            bufWIdx  = bufPtr_q;
            bufWData = linkRx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Scratch buffer, one register per byte

    for (genvar i = 0; i < BUF_BYTES; i++) begin : g_buf
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                varBuf_q[i] <= 8'h00;
            end else if (bufWe && bufWIdx == BUF_IDX_W'(i)) begin
                varBuf_q[i] <= bufWData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            listSel_q   <= 1'b0;
            stepIdx_q   <= '0;
            stepTotal_q <= '0;
            op_q        <= OP_DELAY;
            val0_q      <= '0;
            val1_q      <= '0;
            byteNum_q   <= '0;
            byteTotal_q <= '0;
            bufPtr_q    <= '0;
            busy        <= 1'b0;
            initDone    <= 1'b0;
            exitDone    <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (connectStart) begin
                        listSel_q   <= 1'b0;
                        stepIdx_q   <= '0;
                        stepTotal_q <= initSteps;
                        initDone    <= 1'b0;
                        exitDone    <= 1'b0;
                        busy        <= 1'b1;
                        state_q     <= (initSteps == '0) ? ST_NEXT : ST_FETCH;
                    end else if (programDone && initDone) begin
                        // Programming may only be reported once connect is complete
                        listSel_q   <= 1'b1;
                        stepIdx_q   <= '0;
                        stepTotal_q <= exitSteps;
                        exitDone    <= 1'b0;
                        busy        <= 1'b1;
                        state_q     <= (exitSteps == '0) ? ST_NEXT : ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    {op_q, val0_q, val1_q} <= stepMem[{listSel_q, stepIdx_q[STEP_AW-1:0]}];
                    state_q <= ST_EXEC;
                end
                ST_EXEC: begin
                    byteNum_q   <= '0;
                    byteTotal_q <= xferCount;
                    bufPtr_q    <= val0_q[BUF_IDX_W-1:0];
                    case (op_q)
                        OP_DELAY: begin
                            state_q <= (val0_q == '0) ? ST_NEXT : ST_DELAY;
                        end
                        OP_WRITE, OP_BUF_RD, OP_BUF_WR: begin
                            state_q <= (xferCount == '0) ? ST_NEXT : ST_XFER;
                        end
                        default: begin
                            state_q <= ST_NEXT;
                        end
                    endcase
                end
                ST_XFER: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (ackNew) begin
                        byteNum_q <= byteNum_q + 1'b1;
                        bufPtr_q  <= bufPtr_q + 1'b1;
                        state_q   <= lastByte ? ST_NEXT : ST_XFER;
                    end
                end
                ST_DELAY: begin
                    if (msLeft_q == VAL0_W'(1) && tick_q == TICK_W'(CYCLES_PER_MS - 1)) begin
                        state_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    // A step starts only once the previous one has fully ended
                    if (stepIdx_q + 1'b1 >= stepTotal_q) begin
                        busy      <= 1'b0;
                        state_q   <= ST_IDLE;
                        stepIdx_q <= '0;
                        if (listSel_q) begin
                            exitDone <= 1'b1;
                        end else begin
                            initDone <= 1'b1;
                        end
                    end else begin
                        stepIdx_q <= stepIdx_q + 1'b1;
                        state_q   <= ST_FETCH;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond delay counter

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msLeft_q <= '0;
            tick_q   <= '0;
        end else if (state_q == ST_EXEC) begin
            msLeft_q <= val0_q;
            tick_q   <= '0;
        end else if (state_q == ST_DELAY) begin
            if (tick_q == TICK_W'(CYCLES_PER_MS - 1)) begin
                tick_q   <= '0;
                msLeft_q <= msLeft_q - 1'b1;
            end else begin
                tick_q <= tick_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chip select

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            csN <= CS_IDLE;
        end else if (state_q == ST_EXEC && op_q == OP_CS_ON) begin
            csN <= 1'b0;
        end else if (state_q == ST_EXEC && op_q == OP_CS_OFF) begin
            csN <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte handshake toward the link domain. txByte_q only changes in the same cycle as a new
    // request, so the link side may read it whole once it sees the toggle.

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reqTgl_q <= 1'b0;
            txByte_q <= 8'h00;
        end else if (state_q == ST_XFER) begin
            txByte_q <= txNext;
            reqTgl_q <= ~reqTgl_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ackA_q    <= 1'b0;
            ackB_q    <= 1'b0;
            ackSeen_q <= 1'b0;
        end else begin
            ackA_q <= linkAck;
            ackB_q <= ackA_q;
            if (ackNew) begin
                ackSeen_q <= ackB_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial shifter on the link clock

    sse_link u_link (
        .linkClk (linkClk),
        .rst     (rst),
        .reqTgl  (reqTgl_q),
        .txByte  (txByte_q),
        .miso    (miso),
        .ackTgl  (linkAck),
        .rxByte  (linkRx),
        .sck     (sck),
        .mosi    (mosi)
    );

endmodule

// *** inc/sse_pkg.sv ***
package sse_pkg;

    // Scratch buffer and step store geometry
    localparam int BUF_BYTES   = 16;
    localparam int BUF_IDX_W   = 4;
    localparam int BYTE_CNT_W  = 5;
    localparam int STEP_DEPTH  = 32;
    localparam int STEP_AW     = 5;
    localparam int STEP_CNT_W  = 6;

    // Step word layout: opcode | value0 | value1 (byte 0 of value1 in bits 7:0)
    localparam int OP_W        = 4;
    localparam int VAL0_W      = 16;
    localparam int VAL1_W      = 128;
    localparam int STEP_W      = 148;
    localparam int OP_LSB      = 144;
    localparam int VAL0_LSB    = 128;
    localparam int VAL1_LSB    = 0;

    // Byte shifted out while reading into the scratch buffer
    localparam logic [7:0] FILL_BYTE = 8'hff;

    // Idle levels of the link pins
    localparam logic CS_IDLE   = 1'b1;
    localparam logic SCK_IDLE  = 1'b0;
    localparam logic MOSI_IDLE = 1'b0;

    // Delay unit and the clock rate it is counted in
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_IN_NS      = 1000000;
    localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

    // Link clock cycles per half period of the serial clock
    localparam int SCK_HALF      = 4;
    localparam int SCK_PH_W      = 2;
    localparam int BITS_PER_BYTE = 8;

    typedef enum logic [3:0] {
        OP_DELAY   = 4'h0,
        OP_CS_ON   = 4'h1,
        OP_CS_OFF  = 4'h2,
        OP_WRITE   = 4'h3,
        OP_BUF_RD  = 4'h4,
        OP_BUF_WR  = 4'h5,
        OP_BUF_AND = 4'h6,
        OP_BUF_OR  = 4'h7,
        OP_BUF_XOR = 4'h8
    } sse_op_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FETCH = 3'h1,
        ST_EXEC  = 3'h2,
        ST_XFER  = 3'h3,
        ST_WAIT  = 3'h4,
        ST_DELAY = 3'h5,
        ST_NEXT  = 3'h6
    } sse_state_type;

endpackage

// *** rtl/sse_link.sv ***
`timescale 1ns/100ps
module sse_link (
    input  wire logic       linkClk,
    input  wire logic       rst,
    input  wire logic       reqTgl,
    input  wire logic [7:0] txByte,
    input  wire logic       miso,
    output logic            ackTgl,
    output logic [7:0]      rxByte,
    output logic            sck,
    output logic            mosi
);
    import sse_pkg::*;

    logic                reqA_q;
    logic                reqB_q;
    logic                reqSeen_q;
    logic                misoA_q;
    logic                misoB_q;
    logic                busy_q;
    logic [SCK_PH_W-1:0] phase_q;
    logic [2:0]          bitCnt_q;
    logic [7:0]          shift_q;
    logic [7:0]          rx_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers: request toggle from the engine, serial input from the pin
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            reqA_q  <= 1'b0;
            reqB_q  <= 1'b0;
            misoA_q <= 1'b0;
            misoB_q <= 1'b0;
        end else begin
            reqA_q  <= reqTgl;
            reqB_q  <= reqA_q;
            misoA_q <= miso;
            misoB_q <= misoA_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode 0 byte shifter. Input is sampled at the end of the high phase so the
    // two-stage synchroniser delay stays inside the half period.
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            reqSeen_q <= 1'b0;
            busy_q    <= 1'b0;
            phase_q   <= '0;
            bitCnt_q  <= 3'h0;
            shift_q   <= 8'h00;
            rx_q      <= 8'h00;
            rxByte    <= 8'h00;
            ackTgl    <= 1'b0;
            sck       <= SCK_IDLE;
            mosi      <= MOSI_IDLE;
        end else if (!busy_q) begin
            if (reqB_q != reqSeen_q) begin
                // txByte is held steady by the engine until the acknowledge
                reqSeen_q <= reqB_q;
                busy_q    <= 1'b1;
                shift_q   <= txByte;
                mosi      <= txByte[7];
                phase_q   <= '0;
                bitCnt_q  <= 3'h0;
            end
        end else begin
            phase_q <= phase_q + 1'b1;
            if (phase_q == SCK_PH_W'(SCK_HALF - 1)) begin
                phase_q <= '0;
                if (!sck) begin
                    sck <= 1'b1;
                end else begin
                    sck  <= 1'b0;
                    rx_q <= {rx_q[6:0], misoB_q};
                    if (bitCnt_q == 3'(BITS_PER_BYTE - 1)) begin
                        busy_q <= 1'b0;
                        rxByte <= {rx_q[6:0], misoB_q};
                        ackTgl <= ~ackTgl;
                    end else begin
                        bitCnt_q <= bitCnt_q + 1'b1;
                        shift_q  <= {shift_q[6:0], 1'b0};
                        mosi     <= shift_q[6];
                    end
                end
            end
        end
    end

endmodule

// *** verification/sse_flash_model.sv ***
`timescale 1ns/100ps
module sse_flash_model (
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic csN,
    output logic      miso
);
    logic [7:0] rxSh;
    logic [7:0] txSh;
    int         bitN;
    int         byteN;
    int         frames;
    logic [7:0] got[$];
    initial begin
        miso = 1'b0;
        frames = 0;
    end
    // Each frame answers 0x30, 0x31, ... so buffer contents reveal the byte order
    always @(negedge csN) begin
        bitN = 0;
        byteN = 0;
        txSh = 8'h30;
        frames++;
        miso <= txSh[7];
    end
    // Deselected: show the inverse so a stale capture cannot look right
    always @(posedge csN) miso <= ~miso;
    always @(posedge sck) begin
        if (!csN) begin
            rxSh = {rxSh[6:0], mosi};
            bitN++;
            if (bitN == 8) begin
                got.push_back(rxSh);
                bitN = 0;
                byteN++;
                txSh = 8'h30 + 8'(byteN);
            end
        end
    end
    always @(negedge sck) begin
        if (!csN) miso <= txSh[7-bitN];
    end
endmodule

// *** verification/sse_engine_checker.sv ***
`timescale 1ns/100ps
module sse_engine_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic connectStart,
    input wire logic programDone,
    input wire logic sck,
    input wire logic mosi,
    input wire logic csN,
    input wire logic busy,
    input wire logic initDone,
    input wire logic exitDone
);
    property p_sck_idle_deselected;
        @(posedge linkClk) disable iff (rst) csN |-> !sck;
    endproperty
    a_sck_idle_deselected: assert property (p_sck_idle_deselected)
        else $error("serial clock active while deselected");
    property p_cs_held_in_byte;
        @(posedge linkClk) disable iff (rst) sck |-> $stable(csN);
    endproperty
    a_cs_held_in_byte: assert property (p_cs_held_in_byte)
        else $error("chip select moved inside a byte");
    property p_mosi_stable_high;
        @(posedge linkClk) disable iff (rst) sck |-> $stable(mosi);
    endproperty
    a_mosi_stable_high: assert property (p_mosi_stable_high)
        else $error("serial out moved while clock high");
    property p_sck_high_len;
        @(posedge linkClk) disable iff (rst) $rose(sck) |-> sck[*4] ##1 !sck;
    endproperty
    a_sck_high_len: assert property (p_sck_high_len)
        else $error("serial clock high phase length wrong");
    property p_sck_low_len;
        @(posedge linkClk) disable iff (rst) $fell(sck) |-> !sck[*4];
    endproperty
    a_sck_low_len: assert property (p_sck_low_len)
        else $error("serial clock low phase too short");
    property p_connect_starts;
        @(posedge ref_clk) disable iff (rst) !busy && connectStart |=> busy && !initDone;
    endproperty
    a_connect_starts: assert property (p_connect_starts)
        else $error("connect did not start init list");
    property p_program_gated;
        @(posedge ref_clk) disable iff (rst)
            !busy && !initDone && programDone && !connectStart |=> !busy;
    endproperty
    a_program_gated: assert property (p_program_gated)
        else $error("exit list started before connect");
    property p_exit_starts;
        @(posedge ref_clk) disable iff (rst)
            !busy && initDone && programDone && !connectStart |=> busy ##0 !exitDone;
    endproperty
    a_exit_starts: assert property (p_exit_starts)
        else $error("exit list did not start");
    property p_done_ends_run;
        @(posedge ref_clk) disable iff (rst) $rose(initDone) || $rose(exitDone) |-> $fell(busy);
    endproperty
    a_done_ends_run: assert property (p_done_ends_run)
        else $error("done flag not tied to end of run");
endmodule
bind sse_engine sse_engine_checker sse_engine_checker_inst (
    .ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .connectStart(connectStart),
    .programDone(programDone), .sck(sck), .mosi(mosi), .csN(csN), .busy(busy),
    .initDone(initDone), .exitDone(exitDone)
);

// *** verification/sse_engine_tb.sv ***
`timescale 1ns/100ps
module sse_engine_tb;
    import sse_pkg::*;
    localparam int MS_CYC = 20;
    logic ref_clk, rst, linkClk, stepWrEn, stepWrList, connectStart, programDone;
    logic miso, sck, mosi, csN, busy, initDone, exitDone;
    logic [STEP_AW-1:0]    stepWrAddr;
    logic [STEP_W-1:0]     stepWrData;
    logic [STEP_CNT_W-1:0] initSteps;
    logic [STEP_CNT_W-1:0] exitSteps;
    int fails;
    int numChecks;
    sse_engine #(.CYCLES_PER_MS(MS_CYC)) sse_engine_inst (
        .ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .stepWrEn(stepWrEn),
        .stepWrList(stepWrList), .stepWrAddr(stepWrAddr), .stepWrData(stepWrData),
        .initSteps(initSteps), .exitSteps(exitSteps), .connectStart(connectStart),
        .programDone(programDone), .miso(miso), .sck(sck), .mosi(mosi), .csN(csN),
        .busy(busy), .initDone(initDone), .exitDone(exitDone));
    sse_flash_model sse_flash_model_inst (.sck(sck), .mosi(mosi), .csN(csN), .miso(miso));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Link clock phase deliberately unrelated to the engine clock
    initial begin
        linkClk = 1'b0;
        #1.3;
        forever #15 linkClk = ~linkClk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [STEP_W-1:0] mk(sse_op_type op, int v0, logic [VAL1_W-1:0] v1);
        return {op, v0[VAL0_W-1:0], v1};
    endfunction
    task automatic load(input logic lst, input logic [STEP_W-1:0] w[$]);
        for (int i = 0; i < w.size(); i++) begin
            @(posedge ref_clk);
            stepWrEn <= 1'b1;
            stepWrList <= lst;
            stepWrAddr <= i[STEP_AW-1:0];
            stepWrData <= w[i];
        end
        @(posedge ref_clk);
        stepWrEn <= 1'b0;
    endtask
    task automatic testGate;
        chk("idle chip select", csN, 1);
        @(posedge ref_clk);
        programDone <= 1'b1;
        @(posedge ref_clk);
        programDone <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk("busy before connect", busy, 0);
        chk("frames before connect", sse_flash_model_inst.frames, 0);
        $display("test gate done");
    endtask
    task automatic testInit;
        logic [7:0] exp[$];
        int cyc;
        int lastLow;
        exp = '{8'ha5, 8'h3c, 8'hff, 8'hff, 8'hff, 8'hcd, 8'h03, 8'hb4};
        cyc = 0;
        lastLow = 0;
        load(1'b0, '{mk(OP_CS_ON, 0, 0), mk(OP_WRITE, 2, 128'h3ca5),
            mk(OP_BUF_RD, 14, 3), mk(OP_CS_OFF, 0, 0), mk(OP_BUF_AND, 15, 8'h0f),
            mk(OP_BUF_OR, 0, 8'h80), mk(OP_BUF_XOR, 14, 8'hff), mk(OP_CS_ON, 0, 0),
            mk(OP_BUF_WR, 14, 3), mk(OP_CS_OFF, 0, 0), mk(OP_DELAY, 1, 0)});
        initSteps <= 6'h0b;
        connectStart <= 1'b1;
        @(posedge ref_clk);
        connectStart <= 1'b0;
        while (initDone !== 1'b1 && cyc < 20000) begin
            @(posedge ref_clk);
            cyc++;
            if (csN === 1'b0) lastLow = cyc;
        end
        chk("init done", initDone, 1);
        chk("bytes on link", sse_flash_model_inst.got.size(), exp.size());
        foreach (exp[i]) chk("link byte", sse_flash_model_inst.got[i], exp[i]);
        chk("frames", sse_flash_model_inst.frames, 2);
        chk("delay span", (cyc - lastLow >= MS_CYC) && (cyc - lastLow <= MS_CYC + 10), 1);
        chk("cs after list", csN, 1);
        $display("test init done");
    endtask
    task automatic testExit;
        int cyc;
        cyc = 0;
        load(1'b1, '{mk(OP_CS_ON, 0, 0), mk(OP_WRITE, 1, 8'h06), mk(OP_CS_OFF, 0, 0)});
        exitSteps <= 6'h03;
        programDone <= 1'b1;
        @(posedge ref_clk);
        programDone <= 1'b0;
        while (exitDone !== 1'b1 && cyc < 20000) begin
            @(posedge ref_clk);
            cyc++;
        end
        chk("exit done", exitDone, 1);
        chk("exit byte", sse_flash_model_inst.got[8], 8'h06);
        chk("init flag kept", initDone, 1);
        $display("test exit done");
    endtask
    task automatic reportAndStop;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Full run is about 3800 engine cycles; allow generous headroom
    initial begin
        #200000;
        fails++;
        reportAndStop();
    end
    initial begin
        fails = 0;
        numChecks = 0;
        rst = 1'b1;
        stepWrEn = 1'b0;
        stepWrList = 1'b0;
        stepWrAddr = '0;
        stepWrData = '0;
        initSteps = '0;
        exitSteps = '0;
        connectStart = 1'b0;
        programDone = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        testGate();
        testInit();
        testExit();
        reportAndStop();
    end
endmodule
